// ===== hdl/sarh_pkg.sv
package sarh_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and pin timing
   localparam int CLK_PERIOD_NS   = 5;
   localparam int TRIG_LOW_NS     = 20;
   localparam int TRIG_HIGH_NS    = 20;
   localparam int ACQ_NS          = 150;
   localparam int BUS_HOLD_NS     = 40;
   localparam int RD_LOW_NS       = 50;
   localparam int RD_HIGH_NS      = 20;
   localparam int DATA_EN_NS      = 30;
   localparam int LAST_RD_HOLD_NS = 50;
   localparam int BUSY_MAX_NS     = 630;

   // least times round up
   localparam int TRIG_LOW_CYC     = (TRIG_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRIG_HIGH_CYC    = (TRIG_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACQ_CYC          = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUS_HOLD_CYC     = (BUS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_LOW_CYC       = (RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_HIGH_CYC      = (RD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DATA_EN_CYC      = (DATA_EN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LAST_RD_HOLD_CYC = (LAST_RD_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // busy timeout: wait past the longest busy-high time plus the sync delay
   localparam int BUSY_TMO_CYC     = (BUSY_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 4;

   localparam int CNT_W       = 8;
   localparam int DATA_W      = 16;
   localparam int FIFO_DEPTH  = 16;

   ////////////////////////////////////////////////////////////////////////////
   // grouped signals
   typedef struct packed {
      logic [DATA_W-1:0] code;
      logic              timeout;
   } sarh_sample_s;

   typedef struct packed {
      logic              conversion_trigger_n;
      logic              cs_n;
      logic              rd_n;
      logic              byte_fold;
      logic              bus_width_select;
   } sarh_pins_s;

   localparam sarh_pins_s PINS_IDLE = '{conversion_trigger_n: 1'b1, cs_n: 1'b1,
                                        rd_n: 1'b1, byte_fold: 1'b0,
                                        bus_width_select: 1'b0};

   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0000,
      ST_TRIG_LO = 4'b0001,
      ST_TRIG_HI = 4'b0011,
      ST_BUSY    = 4'b0010,
      ST_RD1     = 4'b0110,
      ST_GAP     = 4'b0111,
      ST_RD2     = 4'b0101,
      ST_PUSH    = 4'b0100,
      ST_ACQ     = 4'b1100
   } sarh_state_e;

endpackage

// ===== hdl/sarh_fifo.sv
module sarh_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0]      cnt_reg, cnt_next;
   logic             push, pop;

   assign in_ready  = (cnt_reg != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem_reg[rd_reg];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      mem_next = mem_reg;
      wr_next  = wr_reg;
      rd_next  = rd_reg;
      cnt_next = cnt_reg;
      if (push) begin
         mem_next[wr_reg] = in_data;
         wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + AW'(1);
      end
      if (pop) begin
         rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + AW'(1);
      end
      if (push && !pop) begin
         cnt_next = cnt_reg + (AW+1)'(1);
      end else if (pop && !push) begin
         cnt_next = cnt_reg - (AW+1)'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         cnt_reg <= cnt_next;
      end
      mem_reg <= mem_next;
   end

   chk_fifo_no_overrun: assert property (@(posedge clk) disable iff (rst)
      cnt_reg <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// ===== hdl/sarh_host.sv
// Operation
// - host waits 150ns busy low before trigger; the host times 150ns from push or reset, not from busy
// - trigger low and high each 20ns
// - no bus activity 40ns after trigger
// - chip select falls no later than read
// - read strobe low at least 50ns
// - read strobe high 20ns between reads
// - last read ends 50ns before trigger
// - no byte select change near busy fall
// - read falls only after byte select settles
module sarh_host #(
   parameter bit BYTE_MODE = 1'b0
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   run,
   output logic                        conversion_trigger_n,
   output logic                        cs_n,
   output logic                        rd_n,
   output logic                        byte_fold,
   output logic                        bus_width_select,
   input  wire logic                   busy,
   input  wire logic [15:0]            db_in,
   output logic [15:0]                 sample_data,
   output logic                        sample_timeout,
   output logic                        sample_valid,
   input  wire logic                   sample_ready,
   output logic                        converting
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic        busy_s1_reg, busy_s2_reg;
   logic [15:0] db_s1_reg, db_s2_reg;

   always_ff @(posedge clk) begin
      busy_s1_reg <= busy;
      busy_s2_reg <= busy_s1_reg;
      db_s1_reg   <= db_in;
      db_s2_reg   <= db_s1_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   sarh_pkg::sarh_state_e         st_reg, st_next;
   sarh_pkg::sarh_pins_s          pins_reg, pins_next;
   logic [sarh_pkg::CNT_W-1:0]    cnt_reg, cnt_next;
   logic [sarh_pkg::CNT_W-1:0]    since_trig_reg, since_trig_next;
   logic [sarh_pkg::DATA_W-1:0]   word_reg, word_next;
   logic                          tmo_reg, tmo_next;
   logic                          fifo_in_ready;
   logic                          push;
   sarh_pkg::sarh_sample_s        fifo_in, fifo_out;

   function automatic logic [sarh_pkg::CNT_W-1:0] cyc(input int n);
      cyc = sarh_pkg::CNT_W'(n);
   endfunction

   assign push    = (st_reg == sarh_pkg::ST_PUSH);
   assign fifo_in = '{code: word_reg, timeout: tmo_reg};

   always_comb begin
      st_next         = st_reg;
      pins_next       = pins_reg;
      cnt_next        = (cnt_reg != '0) ? cnt_reg - cyc(1) : cnt_reg;
      since_trig_next = (since_trig_reg != '1) ? since_trig_reg + cyc(1) : since_trig_reg;
      word_next       = word_reg;
      tmo_next        = tmo_reg;
      case (st_reg)
         sarh_pkg::ST_IDLE: begin
            // idle holds the bus quiet long enough before a new trigger
            if (run && cnt_reg == '0) begin
               pins_next.conversion_trigger_n = 1'b0;
               cnt_next        = cyc(sarh_pkg::TRIG_LOW_CYC);
               since_trig_next = '0;
               tmo_next        = 1'b0;
               st_next         = sarh_pkg::ST_TRIG_LO;
            end
         end
         sarh_pkg::ST_TRIG_LO: begin
            if (cnt_reg == cyc(1)) begin
               pins_next.conversion_trigger_n = 1'b1;
               // busy may rise late, so the timeout also covers the rise delay
               cnt_next = cyc(sarh_pkg::BUSY_TMO_CYC + sarh_pkg::BUS_HOLD_CYC);
               st_next  = sarh_pkg::ST_TRIG_HI;
            end
         end
         sarh_pkg::ST_TRIG_HI: begin
            // wait out the bus hold, and let a late busy rise pass the sync stages
            if (since_trig_reg >= cyc(sarh_pkg::BUS_HOLD_CYC + 3)) begin
               st_next = sarh_pkg::ST_BUSY;
            end
         end
         sarh_pkg::ST_BUSY: begin
            // busy low means the first result half is already valid
            if (!busy_s2_reg || cnt_reg == '0) begin
               tmo_next           = busy_s2_reg;
               pins_next.cs_n     = 1'b0;
               pins_next.rd_n     = 1'b0;
               // first read is unfolded, so no fold change lands near busy falling
               pins_next.byte_fold = 1'b0;
               pins_next.bus_width_select = BYTE_MODE;
               cnt_next = cyc(sarh_pkg::RD_LOW_CYC + 2);
               st_next  = sarh_pkg::ST_RD1;
            end
         end
         sarh_pkg::ST_RD1: begin
            // read strobe held long enough to cover enable time and the sync stages
            if (cnt_reg == cyc(1)) begin
               pins_next.rd_n = 1'b1;
               if (BYTE_MODE) begin
                  word_next[15:8]     = db_s2_reg[15:8];
                  pins_next.byte_fold = 1'b1;
                  cnt_next = cyc(sarh_pkg::RD_HIGH_CYC + sarh_pkg::DATA_EN_CYC);
                  st_next  = sarh_pkg::ST_GAP;
               end else begin
                  word_next = db_s2_reg;
                  pins_next.cs_n = 1'b1;
                  st_next        = sarh_pkg::ST_PUSH;
               end
            end
         end
         sarh_pkg::ST_GAP: begin
            if (cnt_reg == cyc(1)) begin
               pins_next.rd_n = 1'b0;
               cnt_next = cyc(sarh_pkg::RD_LOW_CYC + 2);
               st_next  = sarh_pkg::ST_RD2;
            end
         end
         sarh_pkg::ST_RD2: begin
            if (cnt_reg == cyc(1)) begin
               word_next[7:0]      = db_s2_reg[15:8];
               pins_next.rd_n      = 1'b1;
               pins_next.cs_n      = 1'b1;
               pins_next.byte_fold = 1'b0;
               st_next = sarh_pkg::ST_PUSH;
            end
         end
         sarh_pkg::ST_PUSH: begin
            // a full fifo stalls the sequencer here
            if (fifo_in_ready) begin
               cnt_next = cyc(sarh_pkg::ACQ_CYC);
               st_next  = sarh_pkg::ST_ACQ;
            end
         end
         sarh_pkg::ST_ACQ: begin
            // acquisition time dominates the last-read hold and trigger-high time
            if (cnt_reg == '0) begin
               st_next = sarh_pkg::ST_IDLE;
            end
         end
         default: begin
            st_next   = sarh_pkg::ST_IDLE;
            pins_next = sarh_pkg::PINS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg         <= sarh_pkg::ST_IDLE;
         pins_reg       <= sarh_pkg::PINS_IDLE;
         cnt_reg        <= cyc(sarh_pkg::ACQ_CYC);
         since_trig_reg <= '1;
         word_reg       <= '0;
         tmo_reg        <= 1'b0;
      end else begin
         st_reg         <= st_next;
         pins_reg       <= pins_next;
         cnt_reg        <= cnt_next;
         since_trig_reg <= since_trig_next;
         word_reg       <= word_next;
         tmo_reg        <= tmo_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output registers
   logic conv_reg, conv_next;

   assign conv_next = (st_next != sarh_pkg::ST_IDLE) && (st_next != sarh_pkg::ST_ACQ);

   always_ff @(posedge clk) begin
      if (rst) begin
         conv_reg <= 1'b0;
      end else begin
         conv_reg <= conv_next;
      end
   end

   assign conversion_trigger_n = pins_reg.conversion_trigger_n;
   assign cs_n                 = pins_reg.cs_n;
   assign rd_n                 = pins_reg.rd_n;
   assign byte_fold            = pins_reg.byte_fold;
   assign bus_width_select     = pins_reg.bus_width_select;
   assign converting           = conv_reg;

   ////////////////////////////////////////////////////////////////////////////
   // result fifo
   sarh_fifo #(
      .WIDTH ($bits(sarh_pkg::sarh_sample_s)),
      .DEPTH (sarh_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_data   (fifo_in),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out),
      .out_valid (sample_valid),
      .out_ready (sample_ready)
   );

   assign sample_data    = fifo_out.code;
   assign sample_timeout = fifo_out.timeout;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   chk_trig_low_width: assert property (@(posedge clk) disable iff (rst)
      $fell(conversion_trigger_n) |-> !conversion_trigger_n [*4])
      else $error("trigger low too short");
   chk_no_read_early: assert property (@(posedge clk) disable iff (rst)
      $fell(conversion_trigger_n) |-> rd_n [*8])
      else $error("read strobe low too soon after trigger");
   chk_cs_before_rd: assert property (@(posedge clk) disable iff (rst)
      !rd_n |-> !cs_n) else $error("read strobe low without chip select");
   chk_rd_low_width: assert property (@(posedge clk) disable iff (rst)
      $fell(rd_n) |-> !rd_n [*8]) else $error("read strobe low too short");
   chk_rd_high_gap: assert property (@(posedge clk) disable iff (rst)
      ($rose(rd_n) && !cs_n) |-> rd_n [*4]) else $error("read strobe high too short");
   chk_read_to_trig: assert property (@(posedge clk) disable iff (rst)
      $rose(cs_n) |-> conversion_trigger_n [*8]) else $error("trigger too soon after read");
   chk_fold_setup: assert property (@(posedge clk) disable iff (rst)
      $changed(byte_fold) |-> rd_n) else $error("byte fold changed during read");
   // cycles the synced busy has stayed low, saturating
   logic [sarh_pkg::CNT_W-1:0] low_cnt_reg, low_cnt_next;

   assign low_cnt_next = busy_s2_reg ? '0
                       : (low_cnt_reg != '1) ? low_cnt_reg + cyc(1) : low_cnt_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         low_cnt_reg <= '0;
      end else begin
         low_cnt_reg <= low_cnt_next;
      end
   end

   chk_acq_wait: assert property (@(posedge clk) disable iff (rst)
      $fell(conversion_trigger_n) |-> (low_cnt_reg >= cyc(sarh_pkg::ACQ_CYC)))
      else $error("acquisition time not kept");
endmodule

// ===== dv/sarh_adc_model.sv
module sarh_adc_model #(
   parameter int EN_NS   = 20,
   parameter int CONV_NS = 600,
   parameter int RISE_NS = 35
) (
   input  wire sarh_pkg::sarh_pins_s pins,
   input  wire logic [15:0]          code,
   input  wire logic                 hang,
   output logic                      busy,
   output logic [15:0]               db,
   output logic [7:0]                viol
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] res = 16'h0000;
   logic        en = 1'b0;
   logic        sel_ok = 1'b1;
   realtime     t_trig_fall = -1000.0;
   realtime     t_trig_rise = -1000.0;
   realtime     t_busy_fall = -1000.0;
   realtime     t_rd_fall = -1000.0;
   realtime     t_rd_rise = -1000.0;
   wire logic   acc = !pins.cs_n && !pins.rd_n;

   initial begin
      busy = 1'b0;
      viol = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // conversion
   always @(negedge pins.conversion_trigger_n) begin
      #(RISE_NS) busy = 1'b1;
      #(CONV_NS - RISE_NS);
      wait (!hang);
      res = code;
      #15 busy = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // data bus, inverse pattern while released or unsettled
   always @(acc) en <= #(EN_NS) acc;
   always @(pins.byte_fold or pins.bus_width_select) begin
      sel_ok <= 1'b0;
      sel_ok <= #(EN_NS) 1'b1;
   end
   wire logic [15:0] view = pins.byte_fold ? {res[7:0], 8'hff} : res;
   assign db = (en && sel_ok) ? view : ~view;

   ////////////////////////////////////////////////////////////////////////////
   // host timing faults
   always @(negedge pins.conversion_trigger_n) begin
      if ($realtime - t_busy_fall < 150.0) viol++;
      if ($realtime - t_rd_rise < 50.0) viol++;
      if ($realtime - t_trig_rise < 20.0) viol++;
      t_trig_fall = $realtime;
   end
   always @(posedge pins.conversion_trigger_n) begin
      if ($realtime - t_trig_fall < 20.0) viol++;
      t_trig_rise = $realtime;
   end
   always @(negedge busy) t_busy_fall = $realtime;
   // pins that move on one edge are judged after they have all settled
   always @(negedge pins.cs_n) if ($realtime - t_trig_fall < 40.0) viol++;
   always @(posedge pins.cs_n) #1ps if (pins.rd_n === 1'b0) viol++;
   always @(negedge pins.rd_n) begin
      if ($realtime - t_trig_fall < 40.0) viol++;
      if ($realtime - t_rd_rise < 20.0) viol++;
      t_rd_fall = $realtime;
      #1ps if (pins.cs_n !== 1'b0) viol++;
   end
   always @(posedge pins.rd_n) begin
      if (t_rd_fall > t_rd_rise && $realtime - t_rd_fall < 50.0) viol++;
      t_rd_rise = $realtime;
   end
   always @(pins.byte_fold) #1ps if (pins.rd_n === 1'b0) viol++;
endmodule

// ===== dv/test_sarh_host.sv
module test_sarh_host;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [15:0] code;
      logic [15:0] exp;
   } sarh_row_s;
   localparam sarh_row_s ROWS [7] = '{'{16'h0000, 16'h0000}, '{16'hffff, 16'hffff},
      '{16'h8001, 16'h8001}, '{16'h1234, 16'h1234}, '{16'ha5c3, 16'ha5c3},
      '{16'h00ff, 16'h00ff}, '{16'hff00, 16'hff00}};

   logic                      clk;
   logic                      rst;
   logic [1:0]                run;
   logic [1:0]                rdy;
   logic [15:0]               code;
   logic                      hang;
   int                        err_count;
   int                        num_checks;
   wire sarh_pkg::sarh_pins_s pins [2];
   wire logic [1:0]           busy;
   wire logic [1:0]           tmo;
   wire logic [1:0]           val;
   wire logic [1:0]           conv;
   wire logic [15:0]          db [2];
   wire logic [15:0]          data [2];
   wire logic [7:0]           viol [2];

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // word-mode and byte-mode hosts, each with its own converter
   genvar g;
   for (g = 0; g < 2; g++) begin : gen_dut
      sarh_host #(.BYTE_MODE(g == 1)) i_dut (
         .clk                  (clk),
         .rst                  (rst),
         .run                  (run[g]),
         .conversion_trigger_n (pins[g].conversion_trigger_n),
         .cs_n                 (pins[g].cs_n),
         .rd_n                 (pins[g].rd_n),
         .byte_fold            (pins[g].byte_fold),
         .bus_width_select     (pins[g].bus_width_select),
         .busy                 (busy[g]),
         .db_in                (db[g]),
         .sample_data          (data[g]),
         .sample_timeout       (tmo[g]),
         .sample_valid         (val[g]),
         .sample_ready         (rdy[g]),
         .converting           (conv[g])
      );
      sarh_adc_model #(
         .EN_NS   (g == 1 ? 30 : 20),
         .CONV_NS (g == 1 ? 610 : 600),
         .RISE_NS (g == 1 ? 40 : 35)
      ) i_dev (
         .pins (pins[g]),
         .code (code),
         .hang (hang && g == 0),
         .busy (busy[g]),
         .db   (db[g]),
         .viol (viol[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // compare and handshake tasks
   task automatic check_data(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_flag(input string name, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic wait_conv(input int k, input logic lvl);
      for (int n = 0; n < 1000 && conv[k] !== lvl; n++) @(negedge clk);
      check_flag("converting", lvl, conv[k]);
   endtask

   task automatic pop(input int k, input logic [15:0] exp, input logic exp_tmo);
      for (int n = 0; n < 1000 && val[k] !== 1'b1; n++) @(negedge clk);
      check_flag("sample_valid", 1'b1, val[k]);
      if (!exp_tmo) check_data("sample_data", exp, data[k]);
      check_flag("sample_timeout", exp_tmo, tmo[k]);
      rdy[k] = 1'b1;
      @(negedge clk);
      rdy[k] = 1'b0;
      @(negedge clk);
   endtask

   task automatic check_idle(input int k);
      check_flag("trigger_n", 1'b1, pins[k].conversion_trigger_n);
      check_flag("cs_n", 1'b1, pins[k].cs_n);
      check_flag("rd_n", 1'b1, pins[k].rd_n);
      check_flag("byte_fold", 1'b0, pins[k].byte_fold);
      check_flag("bus_width_select", 1'b0, pins[k].bus_width_select);
      check_flag("sample_valid", 1'b0, val[k]);
      check_flag("converting", 1'b0, conv[k]);
   endtask

   task automatic test_done;
      if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      #200000;
      err_count++;
      test_done();
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst = 1'b1;
      run = 2'b00;
      rdy = 2'b00;
      code = 16'h0000;
      hang = 1'b0;
      err_count = 0;
      num_checks = 0;
      repeat (10) @(negedge clk);
      check_idle(0);
      check_idle(1);
      rst = 1'b0;
      foreach (ROWS[i]) begin
         code = ROWS[i].code;
         run = 2'b11;
         wait_conv(0, 1'b1);
         wait_conv(1, 1'b1);
         run = 2'b00;
         pop(0, ROWS[i].exp, 1'b0);
         pop(1, ROWS[i].exp, 1'b0);
         check_flag("bus_width_select", 1'b0, pins[0].bus_width_select);
         check_flag("bus_width_select", 1'b1, pins[1].bus_width_select);
         wait_conv(0, 1'b0);
         wait_conv(1, 1'b0);
      end
      // back to back until the buffer refuses, then drain in order
      run[0] = 1'b1;
      for (int k = 0; k < 17; k++) begin
         wait_conv(0, 1'b1);
         code = 16'h0100 + 16'(k);
         if (k < 16) wait_conv(0, 1'b0);
      end
      run[0] = 1'b0;
      repeat (300) @(negedge clk);
      check_flag("converting", 1'b1, conv[0]);
      for (int k = 0; k < 17; k++) pop(0, 16'h0100 + 16'(k), 1'b0);
      wait_conv(0, 1'b0);
      // reset in mid-conversion
      run[0] = 1'b1;
      wait_conv(0, 1'b1);
      run[0] = 1'b0;
      repeat (20) @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      check_idle(0);
      rst = 1'b0;
      repeat (200) @(negedge clk);
      // busy that never falls gives a flagged result
      hang = 1'b1;
      run[0] = 1'b1;
      wait_conv(0, 1'b1);
      run[0] = 1'b0;
      pop(0, 16'h0000, 1'b1);
      hang = 1'b0;
      wait_conv(0, 1'b0);
      repeat (200) @(negedge clk);
      check_data("timing faults word", 16'h0000, {8'h00, viol[0]});
      check_data("timing faults byte", 16'h0000, {8'h00, viol[1]});
      test_done();
   end
endmodule
